// ===== hdl/fctap_coeff_reg.sv
// one sixteen bit coefficient register with byte lane writes
`timescale 1ns/1ps
`default_nettype none

module fctap_coeff_reg
   import fctap_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   input  wire logic                     wrEn,
   input  wire logic [FCT_REG_BYTES-1:0] wrStrb,
   input  wire logic [FCT_REG_W-1:0]     wrData,
   output logic      [FCT_REG_W-1:0]     regVal,
   output logic      [FCT_REG_W-1:0]     regNxt
);

   fctap_reg_state_t s_r;
   fctap_reg_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      if (wrEn) begin
         for (int b = 0; b < FCT_REG_BYTES; b++) begin
            if (wrStrb[b]) begin
               s_nxt.value[b*8 +: 8] = wrData[b*8 +: 8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s_r <= '{value: FCT_REG_RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regVal = s_r.value;
   assign regNxt = nrst ? s_nxt.value : FCT_REG_RST;

endmodule
`default_nettype wire

// ===== hdl/fctap_pkg.sv
// constants and state layout for the tap six to nine coefficient store
package fctap_pkg;

   // apb data and address widths
   localparam int FCT_DATA_W   = 32;
   localparam int FCT_ADDR_W   = 14;
   localparam int FCT_IDX_W    = 12;
   localparam int FCT_STRB_W   = FCT_DATA_W / 8;

   // coefficient register layout
   localparam int FCT_REG_W    = 16;
   localparam int FCT_REG_BYTES = FCT_REG_W / 8;
   localparam int FCT_COEFF_W  = 12;
   localparam int FCT_COEFF_MSB = 11;

   // filter shape
   localparam int FCT_TOTAL_TAPS = 9;
   localparam int FCT_CENTER_TAP = 5;
   localparam int FCT_CENTER_W   = 18;
   localparam int FCT_FIRST_TAP  = 6;
   localparam int FCT_NUM_REGS   = 4;

   // register indices; byte address is four times the index
   localparam logic [FCT_IDX_W-1:0] FCT_IDX_TAP6   = 12'h423;
   localparam logic [FCT_IDX_W-1:0] FCT_IDX_TAP7   = 12'h425;
   localparam logic [FCT_IDX_W-1:0] FCT_IDX_TAP8   = 12'h427;
   localparam logic [FCT_IDX_W-1:0] FCT_IDX_TAP9   = 12'h429;
   localparam logic [FCT_IDX_W-1:0] FCT_IDX_STATUS = 12'h42b;

   // index table, entry 0 is the sixth tap
   localparam logic [FCT_NUM_REGS-1:0][FCT_IDX_W-1:0] FCT_TAP_IDX = {
      FCT_IDX_TAP9, FCT_IDX_TAP8, FCT_IDX_TAP7, FCT_IDX_TAP6
   };

   // reset values
   localparam logic [FCT_REG_W-1:0]   FCT_REG_RST   = 16'h0000;
   localparam logic [FCT_COEFF_W-1:0] FCT_COEFF_RST = 12'h000;
   localparam logic [FCT_DATA_W-1:0]  FCT_RDATA_RST = 32'h0000_0000;

   // status register fields
   localparam int FCT_STAT_MODE_BIT = 0;
   localparam int FCT_STAT_NZ_LSB   = 4;

   typedef logic [FCT_NUM_REGS-1:0][FCT_COEFF_W-1:0] fctap_coeff_vec_t;

   // state of the top module
   typedef struct packed {
      logic                    modeMeta;
      logic                    modeSync;
      logic [FCT_DATA_W-1:0]   rdata;
      logic                    slvErr;
      logic [FCT_NUM_REGS-1:0] loadPulse;
      fctap_coeff_vec_t        chanA;
      fctap_coeff_vec_t        single;
   } fctap_top_state_t;

   // state of one coefficient register
   typedef struct packed {
      logic [FCT_REG_W-1:0] value;
   } fctap_reg_state_t;

endpackage

// ===== hdl/fctap_taps_six_to_nine.sv
// equalizer filter coefficient store for taps six to nine, apb slave
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - bits 11:0 of each register are a signed two's complement tap weight
// - sixth-tap register weights channel A tap six in dual-channel mode
// - register 0x425 weights channel A tap seven in dual-channel mode
// - register 0x427 weights channel A tap eight in dual-channel mode
// - register 0x429 weights channel A tap nine in dual-channel mode
// - single-channel mode uses the same registers as combined taps six to nine
// - reset clears every register fully; reserved bits stay readable and writable
// - nine taps total; center tap five is 18 bits, these are 12 bits

module fctap_taps_six_to_nine
   import fctap_pkg::*;
#(
   parameter int ADDR_W     = FCT_ADDR_W,
   parameter int TOTAL_TAPS = FCT_TOTAL_TAPS,
   parameter int COEFF_W    = FCT_COEFF_W
)(
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   input  wire logic                        singleChanMode,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ADDR_W-1:0]           paddr,
   input  wire logic [FCT_DATA_W-1:0]       pwdata,
   input  wire logic [FCT_STRB_W-1:0]       pstrb,
   output logic                             pready,
   output logic      [FCT_DATA_W-1:0]       prdata,
   output logic                             pslverr,
   output logic signed [FCT_COEFF_W-1:0]    chanATap6Coeff,
   output logic signed [FCT_COEFF_W-1:0]    chanATap7Coeff,
   output logic signed [FCT_COEFF_W-1:0]    chanATap8Coeff,
   output logic signed [FCT_COEFF_W-1:0]    chanATap9Coeff,
   output logic signed [FCT_COEFF_W-1:0]    singleTap6Coeff,
   output logic signed [FCT_COEFF_W-1:0]    singleTap7Coeff,
   output logic signed [FCT_COEFF_W-1:0]    singleTap8Coeff,
   output logic signed [FCT_COEFF_W-1:0]    singleTap9Coeff,
   output logic      [FCT_NUM_REGS-1:0]     coeffLoaded
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks
   // nine tap filter shape
   if (ADDR_W < FCT_ADDR_W) begin : gChkAddr
      $error("address bus too narrow for the coefficient map");
   end
   if (TOTAL_TAPS != FCT_TOTAL_TAPS) begin : gChkTaps
      $error("these taps only fit a nine tap filter");
   end
   if (COEFF_W != FCT_COEFF_W) begin : gChkCoeff
      $error("outer tap coefficients are twelve bits");
   end
   if (FCT_FIRST_TAP + FCT_NUM_REGS - 1 != TOTAL_TAPS) begin : gChkLast
      $error("stored taps must end at the last tap");
   end
   if (FCT_CENTER_TAP >= FCT_FIRST_TAP) begin : gChkCenter
      $error("center tap must precede the stored taps");
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations
   fctap_top_state_t s_r;
   fctap_top_state_t s_nxt;

   logic [FCT_NUM_REGS-1:0]                 tapHit;
   logic [FCT_NUM_REGS-1:0]                 tapWrEn;
   logic [FCT_NUM_REGS-1:0][FCT_REG_W-1:0]  regVal;
   logic [FCT_NUM_REGS-1:0][FCT_REG_W-1:0]  regNxt;
   logic                                    statusHit;
   logic                                    upperZero;
   logic                                    aligned;
   logic                                    anyHit;
   logic                                    setupPhase;
   logic                                    accessWr;
   logic [FCT_IDX_W-1:0]                    wordIdx;
   logic [FCT_DATA_W-1:0]                   readWord;
   logic [FCT_NUM_REGS-1:0]                 tapNonZero;

   ////////////////////////////////////////////////////////////////////////
   // address decode
   assign wordIdx    = paddr[FCT_ADDR_W-1:2];
   assign upperZero  = (paddr >> FCT_ADDR_W) == '0;
   assign aligned    = paddr[1:0] == 2'h0;
   assign statusHit  = upperZero && aligned && (wordIdx == FCT_IDX_STATUS);
   assign anyHit     = statusHit || (tapHit != '0);
   assign setupPhase = psel && !penable;
   assign accessWr   = psel && penable && pwrite;

   // zero wait states: every access phase completes at once
   assign pready  = 1'b1;
   assign prdata  = s_r.rdata;
   assign pslverr = s_r.slvErr && psel && penable;

   ////////////////////////////////////////////////////////////////////////
   // coefficient registers
   genvar gi;
   generate
      for (gi = 0; gi < FCT_NUM_REGS; gi++) begin : gTap
         assign tapHit[gi]     = upperZero && aligned && (wordIdx == FCT_TAP_IDX[gi]);
         assign tapWrEn[gi]    = accessWr && tapHit[gi];
         assign tapNonZero[gi] = regVal[gi][FCT_COEFF_MSB:0] != FCT_COEFF_RST;

         fctap_coeff_reg uReg (
            .ref_clk (ref_clk),
            .nrst    (nrst),
            .wrEn    (tapWrEn[gi]),
            .wrStrb  (pstrb[FCT_REG_BYTES-1:0]),
            .wrData  (pwdata[FCT_REG_W-1:0]),
            .regVal  (regVal[gi]),
            .regNxt  (regNxt[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      readWord = FCT_RDATA_RST;
      for (int i = 0; i < FCT_NUM_REGS; i++) begin
         if (tapHit[i]) begin
            readWord[FCT_REG_W-1:0] = regVal[i];
         end
      end
      if (statusHit) begin
         readWord[FCT_STAT_MODE_BIT] = s_r.modeSync;
         readWord[FCT_STAT_NZ_LSB +: FCT_NUM_REGS] = tapNonZero;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;

      // mode pin crosses in through two flops
      s_nxt.modeMeta = singleChanMode;
      s_nxt.modeSync = s_r.modeMeta;

      // read data and error latched in the setup cycle
      if (setupPhase) begin
         s_nxt.rdata  = pwrite ? FCT_RDATA_RST : readWord;
         s_nxt.slvErr = !anyHit;
      end

      // one cycle pulse per tap written
      s_nxt.loadPulse = tapWrEn;

      // route coefficients to whichever filter is in use
      for (int i = 0; i < FCT_NUM_REGS; i++) begin
         if (s_r.modeSync) begin
            s_nxt.chanA[i]  = FCT_COEFF_RST;
            s_nxt.single[i] = regNxt[i][FCT_COEFF_MSB:0];
         end else begin
            s_nxt.chanA[i]  = regNxt[i][FCT_COEFF_MSB:0];
            s_nxt.single[i] = FCT_COEFF_RST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s_r <= '{
            modeMeta:  1'b0,
            modeSync:  1'b0,
            rdata:     FCT_RDATA_RST,
            slvErr:    1'b0,
            loadPulse: '0,
            chanA:     '0,
            single:    '0
         };
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // signed tap weights
   assign chanATap6Coeff  = $signed(s_r.chanA[0]);
   assign chanATap7Coeff  = $signed(s_r.chanA[1]);
   assign chanATap8Coeff  = $signed(s_r.chanA[2]);
   assign chanATap9Coeff  = $signed(s_r.chanA[3]);
   assign singleTap6Coeff = $signed(s_r.single[0]);
   assign singleTap7Coeff = $signed(s_r.single[1]);
   assign singleTap8Coeff = $signed(s_r.single[2]);
   assign singleTap9Coeff = $signed(s_r.single[3]);
   assign coeffLoaded     = s_r.loadPulse;

endmodule
`default_nettype wire

// ===== tb/fctap_taps_props.sv
// assertion checker for the tap six to nine coefficient store
`timescale 1ns/1ps
`default_nettype none
module fctap_taps_props
   import fctap_pkg::*;
#(
   parameter int ADDR_W     = FCT_ADDR_W,
   parameter int TOTAL_TAPS = FCT_TOTAL_TAPS,
   parameter int COEFF_W    = FCT_COEFF_W
)(
   input wire logic               ref_clk,
   input wire logic               nrst,
   input wire logic               singleChanMode,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic               pready,
   input wire logic [31:0]        prdata,
   input wire logic               pslverr,
   input wire logic signed [11:0] chanATap6Coeff,
   input wire logic signed [11:0] chanATap7Coeff,
   input wire logic signed [11:0] chanATap8Coeff,
   input wire logic signed [11:0] chanATap9Coeff,
   input wire logic signed [11:0] singleTap6Coeff,
   input wire logic signed [11:0] singleTap7Coeff,
   input wire logic signed [11:0] singleTap8Coeff,
   input wire logic signed [11:0] singleTap9Coeff,
   input wire logic [3:0]         coeffLoaded
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
sequence wrFull(a);
   psel && penable && pwrite && paddr == a && pstrb[1:0] == 2'h3;
endsequence
sequence dualHeld;
   (!singleChanMode)[*4];
endsequence
////////////////////////////////////////////////////////////////////////
chk_ready_high: assert property (pready)
   else $error("pready low");
chk_err_phase: assert property (pslverr |-> psel && penable)
   else $error("pslverr outside access");
chk_misalign_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
   else $error("misaligned access not refused");
chk_tap7_pulse: assert property (psel && penable && pwrite && paddr == 14'h1094 |=> coeffLoaded == 4'h2)
   else $error("tap seven load pulse wrong");
chk_pulse_cause: assert property (coeffLoaded != 4'h0 |-> $past(psel && penable && pwrite) && $onehot0(coeffLoaded))
   else $error("load pulse without write");
chk_tap7_dual: assert property (dualHeld ##0 wrFull(14'h1094) |=> chanATap7Coeff == $past(pwdata[11:0]))
   else $error("tap seven weight wrong");
chk_tap9_single: assert property (singleChanMode[*4] ##0 wrFull(14'h10a4) |=> singleTap9Coeff == $past(pwdata[11:0]) && chanATap9Coeff == 12'h000)
   else $error("single tap nine weight wrong");
chk_idle_zero: assert property (dualHeld |-> (singleTap6Coeff | singleTap7Coeff | singleTap8Coeff | singleTap9Coeff) == 12'h000)
   else $error("single filter weights not zero");
chk_reset_clear: assert property (disable iff (1'b0) !nrst |=> coeffLoaded == 4'h0 && prdata == 32'h0 && chanATap6Coeff == 12'h000 && !pslverr)
   else $error("reset did not clear");
endmodule
`default_nettype wire

// ===== tb/tb_fctap_taps_six_to_nine.sv
// self-checking bench for the tap six to nine coefficient store
`timescale 1ns/1ps
`default_nettype none
module tb_fctap_taps_six_to_nine;
logic ref_clk, nrst, mode, psel, penable, pwrite, pready, pslverr, er;
logic [13:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb, loaded;
logic signed [11:0] aOut [4];
logic signed [11:0] sOut [4];
int err_total, cmp_count;
logic [13:0] addrs [4] = '{14'h108c, 14'h1094, 14'h109c, 14'h10a4};
logic [15:0] vals [4] = '{16'h5800, 16'h1123, 16'hf7ff, 16'ha001};
fctap_taps_six_to_nine dut (
   .ref_clk(ref_clk), .nrst(nrst), .singleChanMode(mode), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .chanATap6Coeff(aOut[0]), .chanATap7Coeff(aOut[1]), .chanATap8Coeff(aOut[2]),
   .chanATap9Coeff(aOut[3]), .singleTap6Coeff(sOut[0]), .singleTap7Coeff(sOut[1]),
   .singleTap8Coeff(sOut[2]), .singleTap9Coeff(sOut[3]), .coeffLoaded(loaded)
);
initial begin
   ref_clk = 1'b0;
   forever #5 ref_clk = ~ref_clk;
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
   cmp_count++;
   if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
   end
endtask
task report_and_stop;
   $display("mismatches %0d comparisons %0d", err_total, cmp_count);
   if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
   end else begin
      $display("Result: failed");
   end
   $finish;
endtask
// one apb transfer, called just after a rising edge
task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                   input logic [3:0] s, output logic [31:0] r, output logic e);
   psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
   @(posedge ref_clk);
   penable <= 1'b1;
   // the wait ends once pready is high; the watchdog ends it if pready never rises
   do begin
      @(posedge ref_clk);
   end while (pready !== 1'b1);
   r = prdata;
   e = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
   @(posedge ref_clk);
endtask
function automatic logic [31:0] sx(input logic [11:0] v);
   return {{20{v[11]}}, v};
endfunction
initial begin
   repeat (2000) @(posedge ref_clk);
   err_total++;
   $display("[FAIL] %0t bench timeout", $time);
   report_and_stop();
end
initial begin
   {nrst, mode, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   repeat (8) @(posedge ref_clk);
   nrst <= 1'b1;
   @(posedge ref_clk);
   for (int i = 0; i < 4; i++) begin
      apb(1'b0, addrs[i], 32'h0, 4'h0, rd, er);
      chk(rd, 32'h0, "reset value");
      apb(1'b1, addrs[i], {16'hffff, vals[i]}, 4'hf, rd, er);
      chk(32'(aOut[i]), sx(vals[i][11:0]), "dual weight");
      apb(1'b0, addrs[i], 32'h0, 4'h0, rd, er);
      chk(rd, {16'h0, vals[i]}, "readback");
   end
   apb(1'b1, addrs[0], 32'h0000_ffff, 4'h1, rd, er);
   vals[0] = 16'h58ff;
   apb(1'b0, 14'h1090, 32'h0, 4'h0, rd, er);
   chk({rd[30:0], er}, 32'h1, "unmapped read");
   apb(1'b1, 14'h1095, 32'h0000_0123, 4'hf, rd, er);
   chk({31'h0, er}, 32'h1, "misaligned write");
   apb(1'b0, addrs[0], 32'h0, 4'h0, rd, er);
   chk(rd, 32'h0000_58ff, "lane write");
   apb(1'b0, 14'h10ac, 32'h0, 4'h0, rd, er);
   chk(rd, 32'h0000_00f0, "status dual");
   apb(1'b1, 14'h10ac, 32'hffff_ffff, 4'hf, rd, er);
   chk({31'h0, er}, 32'h0, "status write");
   mode <= 1'b1;
   repeat (4) @(posedge ref_clk);
   for (int i = 0; i < 4; i++) begin
      chk(32'(sOut[i]), sx(vals[i][11:0]), "single weight");
      chk(32'(aOut[i]), 32'h0, "idle dual weight");
   end
   apb(1'b0, 14'h10ac, 32'h0, 4'h0, rd, er);
   chk(rd, 32'h0000_00f1, "status single");
   apb(1'b1, addrs[3], 32'h0000_0800, 4'hf, rd, er);
   chk(32'(sOut[3]), 32'hffff_f800, "single write");
   mode <= 1'b0;
   repeat (4) @(posedge ref_clk);
   chk(32'(aOut[3]), 32'hffff_f800, "back to dual");
   // second reset in mid-run must clear written registers
   nrst <= 1'b0;
   repeat (2) @(posedge ref_clk);
   nrst <= 1'b1;
   @(posedge ref_clk);
   chk(32'(aOut[3]), 32'h0, "weight after reset");
   for (int i = 0; i < 4; i++) begin
      apb(1'b0, addrs[i], 32'h0, 4'h0, rd, er);
      chk(rd, 32'h0, "cleared by reset");
   end
   report_and_stop();
end
endmodule
bind fctap_taps_six_to_nine fctap_taps_props #(
   .ADDR_W(ADDR_W), .TOTAL_TAPS(TOTAL_TAPS), .COEFF_W(COEFF_W)
) u_props (
   .ref_clk(ref_clk), .nrst(nrst), .singleChanMode(singleChanMode), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .chanATap6Coeff(chanATap6Coeff), .chanATap7Coeff(chanATap7Coeff),
   .chanATap8Coeff(chanATap8Coeff), .chanATap9Coeff(chanATap9Coeff),
   .singleTap6Coeff(singleTap6Coeff), .singleTap7Coeff(singleTap7Coeff),
   .singleTap8Coeff(singleTap8Coeff), .singleTap9Coeff(singleTap9Coeff),
   .coeffLoaded(coeffLoaded)
);
`default_nettype wire
